// >>> core/ijs_pkg.sv
// ijs_pkg: shared constants and types for the indirect jump sequencer
package ijs_pkg;

  // ----------------------------------------------------------------
  // data widths
  // ----------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int WORD_W = 18;
  localparam int OP_W = 6;
  localparam int PH_W = 4;
  localparam int NUM_PHASES = 16;

  // ----------------------------------------------------------------
  // phase grid, index = (major - 1) * 4 + (minor - 1)
  // ----------------------------------------------------------------
  localparam logic [PH_W-1:0] PH_T11 = 4'h0;
  localparam logic [PH_W-1:0] PH_T13 = 4'h2;
  localparam logic [PH_W-1:0] PH_T14 = 4'h3;
  localparam logic [PH_W-1:0] PH_T21 = 4'h4;
  localparam logic [PH_W-1:0] PH_T22 = 4'h5;
  localparam logic [PH_W-1:0] PH_T23 = 4'h6;
  localparam logic [PH_W-1:0] PH_T24 = 4'h7;
  localparam logic [PH_W-1:0] PH_T31 = 4'h8;
  localparam logic [PH_W-1:0] PH_T33 = 4'hA;
  localparam logic [PH_W-1:0] PH_T34 = 4'hB;
  localparam logic [PH_W-1:0] PH_T41 = 4'hC;
  localparam logic [PH_W-1:0] PH_T42 = 4'hD;
  localparam logic [PH_W-1:0] PH_T43 = 4'hE;
  localparam logic [PH_W-1:0] PH_T44 = 4'hF;

  // ----------------------------------------------------------------
  // function codes (octal 54, 55, 76, 30, 31)
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0] OP_INDIRECT_JUMP_ENABLE_IRQ = 6'h2C;
  localparam logic [OP_W-1:0] OP_INDIRECT_JUMP_PLAIN = 6'h2D;
  localparam logic [OP_W-1:0] OP_RETURN_JUMP = 6'h3E;
  localparam logic [OP_W-1:0] OP_INDIRECT_RETURN_JUMP = 6'h18;
  localparam logic [OP_W-1:0] OP_INDEXED_INDIRECT_RETURN_JUMP = 6'h19;

  // ----------------------------------------------------------------
  // register word indices on the avalon slave
  // ----------------------------------------------------------------
  localparam int REG_AW = 3;
  localparam logic [REG_AW-1:0] REG_CTRL = 3'h0;
  localparam logic [REG_AW-1:0] REG_OPERAND = 3'h1;
  localparam logic [REG_AW-1:0] REG_INDEX = 3'h2;
  localparam logic [REG_AW-1:0] REG_PC = 3'h3;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h4;
  localparam logic [REG_AW-1:0] REG_DREG = 3'h5;
  localparam logic [REG_AW-1:0] REG_XREG = 3'h6;

  // field positions
  localparam int CTRL_START_BIT = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_LOCKOUT_BIT = 2;
  localparam int STAT_INCR_BIT = 3;
  localparam int STAT_ADV_BIT = 4;
  localparam int STAT_INHIBIT_BIT = 5;
  localparam int STAT_SEQ_LSB = 8;

  // reset values
  localparam logic LOCKOUT_RESET = 1'h1;

  // ----------------------------------------------------------------
  // sequence states, gray coded along idle -> I -> R1 -> W
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ISEQ = 2'h1,
    ST_RSEQ = 2'h3,
    ST_WSEQ = 2'h2
  } ijs_state_type;

endpackage : ijs_pkg

// >>> core/ijs_phase_gen.sv
// ijs_phase_gen: sixteen-step timing grid counter, T1.1 through T4.4
`timescale 1ns/100ps
`default_nettype none
module ijs_phase_gen
  import ijs_pkg::*;
#(
  parameter int N_PHASES = NUM_PHASES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  output logic [PH_W-1:0] o_phase
);

  // ----------------------------------------------------------------
  // phase counter
  // ----------------------------------------------------------------
  // parked at T1.1 while idle so every sequence starts on a clean grid
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_phase <= '0;
    end else if (!i_run) begin
      o_phase <= '0;
    end else if (o_phase == PH_W'(N_PHASES - 1)) begin
      o_phase <= '0;
    end else begin
      o_phase <= o_phase + PH_W'(1);
    end
  end

endmodule : ijs_phase_gen
`default_nettype wire

// >>> core/ijs_sequencer.sv
// ijs_sequencer: phase-by-phase control of the indirect and return jump family
//
// Notes on behaviour
// - indirect jumps take target from word's 15 LSBs
// - opcode 54 clears lockout at I-sequence T3.4
// - opcode 55 same, lockout flag untouched
// - return jump stores PC at operand, goes +1
// - opcode 30 stores PC indirectly, jumps storage+1
// - opcode 31 fetches storage address at operand+index
// - read: clear address T4.4, load/start T1.1
// - read: clear data and X T1.3, load X T1.4
// - read: data routing T2.1, D T2.3/T2.4, drop T3.1
// - read T4.2 for 54/55: PC from adder
// - write T1.1: address, start, PC gating, zeros
// - store selector follows arith selector during write
// - write: clear data T1.3, load store T1.4
// - write T2.2: PC loaded from memory address
// - advance: incr off T4.1, PC T4.2, flags T4.3
// - 54/55 run instruction fetch then one read
// - 30/31 run read then write sequence
`timescale 1ns/100ps
`default_nettype none
module ijs_sequencer
  import ijs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  // avalon-mm slave
  input wire logic [REG_AW-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // core memory
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic o_mem_start,
  output logic o_mem_write,
  output logic [WORD_W-1:0] o_mem_wdata,
  input wire logic [WORD_W-1:0] i_mem_rdata,
  // machine flags
  output logic o_irq_lockout,
  output logic o_addr_bus_inhibit
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ijs_state_type state_q;
  logic [PH_W-1:0] phase;
  logic [OP_W-1:0] op_q;
  logic [ADDR_W-1:0] operand_q;
  logic [ADDR_W-1:0] index_q;
  logic [ADDR_W-1:0] pc_q;
  logic [ADDR_W-1:0] mem_addr_reg_q;
  logic [WORD_W-1:0] mem_data_reg_q;
  logic [WORD_W-1:0] x_q;
  logic [WORD_W-1:0] d_q;
  logic pc_increment_flag_q;
  logic advance_control_flag_q;
  logic addr_bus_inhibit_flag_q;
  logic lockout_q;
  logic done_q;
  logic zroute_q;
  logic pgate_q;
  logic waitreq_q;
  logic bus_first;
  logic wr_acc;
  logic start_req;
  logic op_valid;
  logic op_jump;
  logic op_indirect_ret;
  logic in_iseq;
  logic in_rseq;
  logic in_wseq;
  logic [ADDR_W-1:0] adder;
  logic [ADDR_W-1:0] idx_term;
  logic [WORD_W-1:0] arith_sel;
  logic [WORD_W-1:0] store_sel;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // timing grid
  // ----------------------------------------------------------------
  ijs_phase_gen #(
    .N_PHASES(NUM_PHASES)
  ) u_phase (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_run(state_q != ST_IDLE),
    .o_phase(phase)
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  assign in_iseq = (state_q == ST_ISEQ);
  assign in_rseq = (state_q == ST_RSEQ);
  assign in_wseq = (state_q == ST_WSEQ);
  assign op_jump = (op_q == OP_INDIRECT_JUMP_ENABLE_IRQ) || (op_q == OP_INDIRECT_JUMP_PLAIN);
  assign op_indirect_ret = (op_q == OP_INDIRECT_RETURN_JUMP) || (op_q == OP_INDEXED_INDIRECT_RETURN_JUMP);
  assign op_valid = (i_avs_writedata[OP_W-1:0] == OP_INDIRECT_JUMP_ENABLE_IRQ)
                 || (i_avs_writedata[OP_W-1:0] == OP_INDIRECT_JUMP_PLAIN)
                 || (i_avs_writedata[OP_W-1:0] == OP_RETURN_JUMP)
                 || (i_avs_writedata[OP_W-1:0] == OP_INDIRECT_RETURN_JUMP)
                 || (i_avs_writedata[OP_W-1:0] == OP_INDEXED_INDIRECT_RETURN_JUMP);

  // ----------------------------------------------------------------
  // data path selectors
  // ----------------------------------------------------------------
  // index only joins the adder while the storage address is fetched
  assign idx_term = (in_rseq && op_q == OP_INDEXED_INDIRECT_RETURN_JUMP) ? index_q : '0;
  // D holds the operand address, the fetched word (adder takes its low bits) or, from write T3.4, PC; the increment flag drops at T4.1,
  // so the advance control flag (T3.3 to T4.3) carries the +1 into the T4.2 reload of PC
  assign adder = d_q[ADDR_W-1:0] + idx_term
               + {{(ADDR_W-1){1'b0}}, pc_increment_flag_q | advance_control_flag_q};
  // bits 17 to 15 are forced to zero while PC is gated in
  assign arith_sel = zroute_q ? mem_data_reg_q
                   : (pgate_q ? {{(WORD_W-ADDR_W){1'b0}}, pc_q} : '0);
  assign store_sel = in_wseq ? arith_sel : '0;

  // ----------------------------------------------------------------
  // avalon slave handshake
  // ----------------------------------------------------------------
  // one wait state: the read mux is registered before waitrequest drops
  assign bus_first = (i_avs_read || i_avs_write) && waitreq_q;
  assign wr_acc = i_avs_write && !waitreq_q;
  assign start_req = wr_acc && (i_avs_address == REG_CTRL) && i_avs_writedata[CTRL_START_BIT];

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      waitreq_q <= 1'b1;
    end else begin
      waitreq_q <= !bus_first;
    end
  end

  // read mux, unmapped words read as zero
  always_comb begin
    rd_mux = '0;
    if (i_avs_address == REG_CTRL) begin
      rd_mux[OP_W-1:0] = op_q;
    end else if (i_avs_address == REG_OPERAND) begin
      rd_mux[ADDR_W-1:0] = operand_q;
    end else if (i_avs_address == REG_INDEX) begin
      rd_mux[ADDR_W-1:0] = index_q;
    end else if (i_avs_address == REG_PC) begin
      rd_mux[ADDR_W-1:0] = pc_q;
    end else if (i_avs_address == REG_STATUS) begin
      rd_mux[STAT_BUSY_BIT] = (state_q != ST_IDLE);
      rd_mux[STAT_DONE_BIT] = done_q;
      rd_mux[STAT_LOCKOUT_BIT] = lockout_q;
      rd_mux[STAT_INCR_BIT] = pc_increment_flag_q;
      rd_mux[STAT_ADV_BIT] = advance_control_flag_q;
      rd_mux[STAT_INHIBIT_BIT] = addr_bus_inhibit_flag_q;
      rd_mux[STAT_SEQ_LSB +: 2] = state_q;
    end else if (i_avs_address == REG_DREG) begin
      rd_mux[WORD_W-1:0] = d_q;
    end else if (i_avs_address == REG_XREG) begin
      rd_mux[WORD_W-1:0] = x_q;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_avs_readdata <= '0;
    end else if (bus_first && i_avs_read) begin
      o_avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // software-loaded operands
  // ----------------------------------------------------------------
  // operands are frozen while a sequence runs so the grid sees stable inputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      operand_q <= '0;
      index_q <= '0;
    end else if (wr_acc && state_q == ST_IDLE) begin
      if (i_avs_address == REG_OPERAND) begin
        operand_q <= i_avs_writedata[ADDR_W-1:0];
      end else if (i_avs_address == REG_INDEX) begin
        index_q <= i_avs_writedata[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      op_q <= '0;
    end else if (start_req && state_q == ST_IDLE && op_valid) begin
      op_q <= i_avs_writedata[OP_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // sequence control
  // ----------------------------------------------------------------
  // unknown codes and starts while busy are dropped without trace
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_req && op_valid) begin
            state_q <= ST_ISEQ;
          end
        end
        ST_ISEQ: begin
          if (phase == PH_T44) begin
            state_q <= (op_q == OP_RETURN_JUMP) ? ST_WSEQ : ST_RSEQ;
          end
        end
        ST_RSEQ: begin
          if (phase == PH_T44) begin
            state_q <= op_indirect_ret ? ST_WSEQ : ST_IDLE;
          end
        end
        ST_WSEQ: begin
          if (phase == PH_T44) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // sticky completion, a new completion beats a same-cycle clear
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_q <= 1'b0;
    end else if (phase == PH_T44 && (in_wseq || (in_rseq && op_jump))) begin
      done_q <= 1'b1;
    end else if (wr_acc && i_avs_address == REG_STATUS && i_avs_writedata[STAT_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt lockout
  // ----------------------------------------------------------------
  // software may set it again; the fetch-time clear takes priority
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      lockout_q <= LOCKOUT_RESET;
    end else if (in_iseq && phase == PH_T34 && op_q == OP_INDIRECT_JUMP_ENABLE_IRQ) begin
      lockout_q <= 1'b0;
    end else if (wr_acc && i_avs_address == REG_STATUS && i_avs_writedata[STAT_LOCKOUT_BIT]) begin
      lockout_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // memory address register and memory start
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mem_addr_reg_q <= '0;
    end else if ((in_iseq || in_rseq) && phase == PH_T44) begin
      mem_addr_reg_q <= '0;
    end else if ((in_rseq || in_wseq) && phase == PH_T11) begin
      mem_addr_reg_q <= adder;
    end
  end

  // one-cycle start pulse; write is flagged alongside it
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_mem_start <= 1'b0;
      o_mem_write <= 1'b0;
    end else begin
      o_mem_start <= (in_rseq || in_wseq) && phase == PH_T11;
      o_mem_write <= in_wseq && phase == PH_T11;
    end
  end

  // ----------------------------------------------------------------
  // memory data register
  // ----------------------------------------------------------------
  // during write the memory path is blocked and store data goes in
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mem_data_reg_q <= '0;
    end else if ((in_rseq || in_wseq) && phase == PH_T13) begin
      mem_data_reg_q <= '0;
    end else if (in_rseq && phase == PH_T14) begin
      mem_data_reg_q <= i_mem_rdata;
    end else if (in_wseq && phase == PH_T14) begin
      mem_data_reg_q <= store_sel;
    end
  end

  // ----------------------------------------------------------------
  // selector routings
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      zroute_q <= 1'b0;
      pgate_q <= 1'b0;
    end else begin
      if (in_rseq && phase == PH_T21) begin
        zroute_q <= 1'b1;
      end else if (phase == PH_T31 || state_q == ST_IDLE) begin
        zroute_q <= 1'b0;
      end
      if (in_wseq && phase == PH_T11) begin
        pgate_q <= 1'b1;
      end else if (phase == PH_T21 || state_q == ST_IDLE) begin
        pgate_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // X and D operand registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      x_q <= '0;
    end else if ((in_rseq && phase == PH_T13) || (in_wseq && phase == PH_T33)) begin
      x_q <= '0;
    end else if (in_rseq && phase == PH_T14) begin
      x_q <= arith_sel;
    end
  end

  // fetch forms the operand address in D; read replaces it with the word
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      d_q <= '0;
    end else if (in_iseq && phase == PH_T24) begin
      d_q <= {{(WORD_W-ADDR_W){1'b0}}, operand_q};
    end else if ((in_rseq && phase == PH_T23) || (in_wseq && phase == PH_T33)) begin
      d_q <= '0;
    end else if (in_rseq && phase == PH_T24) begin
      d_q <= arith_sel;
    end else if (in_wseq && phase == PH_T34) begin
      d_q <= {{(WORD_W-ADDR_W){1'b0}}, pc_q};
    end
  end

  // ----------------------------------------------------------------
  // program counter
  // ----------------------------------------------------------------
  // writable by software only while idle, to avoid tearing a jump
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_q <= '0;
    end else if (in_rseq && op_jump && phase == PH_T42) begin
      pc_q <= adder;
    end else if (in_wseq && phase == PH_T22) begin
      pc_q <= mem_addr_reg_q;
    end else if (in_wseq && phase == PH_T42) begin
      pc_q <= adder;
    end else if (wr_acc && state_q == ST_IDLE && i_avs_address == REG_PC) begin
      pc_q <= i_avs_writedata[ADDR_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // advance subsequence flags
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pc_increment_flag_q <= 1'b0;
      advance_control_flag_q <= 1'b0;
      addr_bus_inhibit_flag_q <= 1'b0;
    end else if (in_wseq) begin
      if (phase == PH_T31) begin
        pc_increment_flag_q <= 1'b1;
      end else if (phase == PH_T41) begin
        pc_increment_flag_q <= 1'b0;
      end
      if (phase == PH_T33) begin
        advance_control_flag_q <= 1'b1;
      end else if (phase == PH_T43) begin
        advance_control_flag_q <= 1'b0;
      end
      if (phase == PH_T34) begin
        addr_bus_inhibit_flag_q <= 1'b1;
      end else if (phase == PH_T43) begin
        addr_bus_inhibit_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_comb begin
    o_avs_waitrequest = waitreq_q;
    o_mem_addr = mem_addr_reg_q;
    o_mem_wdata = mem_data_reg_q;
    o_irq_lockout = lockout_q;
    o_addr_bus_inhibit = addr_bus_inhibit_flag_q;
  end

endmodule : ijs_sequencer
`default_nettype wire

// >>> tb/ijs_core_mem.sv
// ijs_core_mem: behavioural core memory on the far side of the sequencer
`timescale 1ns/100ps
`default_nettype none
module ijs_core_mem
  import ijs_pkg::*;
(
  input wire logic i_clk,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_start,
  input wire logic i_write,
  input wire logic [WORD_W-1:0] i_wdata,
  output logic [WORD_W-1:0] o_rdata
);
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0] wr_addr_q = '0;
  int rd_cnt_q = 0;
  int wr_cnt_q = 0;
  initial o_rdata = '0;
  // ----------------------------------------------------------------
  // read: word held through T2.1, one edge past the sampling edge, then a moving pattern
  // ----------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_start && !i_write) begin
      rd_cnt_q <= 3;
      o_rdata <= mem[i_addr];
    end else if (rd_cnt_q > 1) begin
      rd_cnt_q <= rd_cnt_q - 1;
    end else begin
      o_rdata <= ~o_rdata; // released bus, so no stale word to lean on
    end
  end
  // write: data is only valid from T2.1, three edges after the start pulse
  always @(posedge i_clk) begin
    if (i_start && i_write) begin
      wr_cnt_q <= 3;
      wr_addr_q <= i_addr;
    end else if (wr_cnt_q > 0) begin
      wr_cnt_q <= wr_cnt_q - 1;
      if (wr_cnt_q == 1) begin
        mem[wr_addr_q] <= i_wdata;
      end
    end
  end
endmodule : ijs_core_mem
`default_nettype wire

// >>> tb/ijs_sequencer_monitor.sv
// ijs_seq_checker: port timing checks for the jump sequencer
`timescale 1ns/100ps
`default_nettype none
module ijs_seq_checker
  import ijs_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic o_mem_start,
  input wire logic o_mem_write,
  input wire logic [WORD_W-1:0] o_mem_wdata,
  input wire logic o_irq_lockout,
  input wire logic o_addr_bus_inhibit
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------------------------------
  // named steps of the write and advance sequences
  // ----------------------------------------------------------------
  sequence s_wr_start;
    o_mem_start && o_mem_write;
  endsequence
  sequence s_inhibit_window;
    o_addr_bus_inhibit [*3] ##1 !o_addr_bus_inhibit;
  endsequence
  a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered in one cycle");
  a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_write_pairs: assert property (o_mem_write |-> o_mem_start)
    else $error("memory write without memory start");
  a_start_pulse: assert property (o_mem_start |=> !o_mem_start)
    else $error("memory start longer than one cycle");
  a_addr_cleared: assert property (o_mem_start |-> $past(o_mem_addr) == 15'h0)
    else $error("address register not cleared before load");
  a_addr_held: assert property (o_mem_start |=> $stable(o_mem_addr) [*8])
    else $error("address register moved during memory cycle");
  a_wdata_top: assert property (s_wr_start |-> ##3 o_mem_wdata[17:16] == 2'h0)
    else $error("stored word has nonzero top bits");
  a_wdata_held: assert property (s_wr_start |-> ##4 $stable(o_mem_wdata) [*8])
    else $error("store data changed during write");
  a_inhibit_start: assert property (s_wr_start |-> ##11 $rose(o_addr_bus_inhibit))
    else $error("inhibit flag not set at T3.4 of write");
  a_inhibit_len: assert property ($rose(o_addr_bus_inhibit) |-> s_inhibit_window)
    else $error("inhibit flag not cleared at T4.3");
  a_lockout_read: assert property ($fell(o_irq_lockout) |-> ##5 (o_mem_start && !o_mem_write))
    else $error("lockout clear not followed by read sequence");
endmodule : ijs_seq_checker
bind ijs_sequencer ijs_seq_checker u_chk (.i_clk(i_clk), .i_resetn(i_resetn), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .o_mem_addr(o_mem_addr),
  .o_mem_start(o_mem_start), .o_mem_write(o_mem_write), .o_mem_wdata(o_mem_wdata),
  .o_irq_lockout(o_irq_lockout), .o_addr_bus_inhibit(o_addr_bus_inhibit));
`default_nettype wire

// >>> tb/ijs_sequencer_bench.sv
// ijs_sequencer_bench: self-checking bench for the jump sequencer
`timescale 1ns/100ps
`default_nettype none
module ijs_sequencer_bench
  import ijs_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [REG_AW-1:0] av_addr = '0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wdata = '0;
  logic [31:0] av_rdata;
  logic av_wait, mem_start, mem_write, lockout, inhibit;
  logic [ADDR_W-1:0] mem_addr;
  logic [WORD_W-1:0] mem_wdata, mem_rdata;
  int err_total = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h37475744;
  logic [OP_W-1:0] ops [0:4] = '{OP_INDIRECT_JUMP_ENABLE_IRQ, OP_INDIRECT_JUMP_PLAIN, OP_RETURN_JUMP,
    OP_INDIRECT_RETURN_JUMP, OP_INDEXED_INDIRECT_RETURN_JUMP};
  initial begin
    forever #5 clk = ~clk;
  end
  ijs_sequencer i_dut (.i_clk(clk), .i_resetn(resetn), .i_avs_address(av_addr), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wdata), .o_avs_readdata(av_rdata), .o_avs_waitrequest(av_wait),
    .o_mem_addr(mem_addr), .o_mem_start(mem_start), .o_mem_write(mem_write), .o_mem_wdata(mem_wdata),
    .i_mem_rdata(mem_rdata), .o_irq_lockout(lockout), .o_addr_bus_inhibit(inhibit));
  ijs_core_mem i_mem (.i_clk(clk), .i_addr(mem_addr), .i_start(mem_start), .i_write(mem_write),
    .i_wdata(mem_wdata), .o_rdata(mem_rdata));
  // ----------------------------------------------------------------
  // helpers: random source, comparison, verdict, bus cycles
  // ----------------------------------------------------------------
  function automatic logic [31:0] next_rand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : next_rand
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [REG_AW-1:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    av_addr <= a;
    av_wdata <= d;
    av_wr <= wr;
    av_rd <= ~wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (av_wait !== 1'b0 && n < 20);
    if (av_wait !== 1'b0) begin
      err_total++;
      close_out();
    end
    q = av_rdata;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk); // gap so the strobe is never reassigned in one step
  endtask : bus
  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, q);
  endtask : rd
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q, st;
    logic [OP_W-1:0] op;
    logic [ADDR_W-1:0] up, ix, pc0, park, exp_pc;
    logic [WORD_W-1:0] word;
    logic jump;
    int n;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("lockout at reset", {31'h0, lockout}, 32'h1);
    check("inhibit at reset", {31'h0, inhibit}, 32'h0);
    rd(REG_STATUS, q);
    check("status at reset", q, 32'h4);
    rd(3'h7, q);
    check("unmapped read", q, 32'h0);
    wr(REG_PC, 32'h1234);
    wr(REG_CTRL, 32'h13F); // unknown code is refused
    rd(REG_STATUS, q);
    check("busy after bad code", {31'h0, q[0]}, 32'h0);
    rd(REG_PC, q);
    check("pc after bad code", q, 32'h1234);
    $display("reset and refusal test done");
    for (int k = 0; k < 15; k++) begin
      op = ops[k % 5];
      q = next_rand();
      up = q[14:0];
      ix = q[29:15];
      q = next_rand();
      word = q[17:0];
      pc0 = q[31:17];
      if (k < 5) begin
        up = 15'h7FFF; // wrap corners for index add and the final +1
        ix = 15'h1;
        word = 18'h3FFFF;
      end
      i_mem.mem[up] = ~word;
      i_mem.mem[(op == OP_INDEXED_INDIRECT_RETURN_JUMP) ? up + ix : up] = word;
      jump = (op == OP_INDIRECT_JUMP_ENABLE_IRQ) || (op == OP_INDIRECT_JUMP_PLAIN);
      park = (op == OP_RETURN_JUMP) ? up : word[14:0];
      exp_pc = jump ? word[14:0] : park + 15'h1;
      wr(REG_STATUS, 32'h6);
      wr(REG_OPERAND, {17'h0, up});
      wr(REG_INDEX, {17'h0, ix});
      wr(REG_PC, {17'h0, pc0});
      wr(REG_CTRL, {23'h0, 1'b1, 2'h0, op});
      wr(REG_PC, {17'h0, ~pc0}); // ignored while busy
      n = 0;
      do begin
        rd(REG_STATUS, st);
        n++;
      end while (st[0] !== 1'b0 && n < 60);
      if (st[0] !== 1'b0) begin
        err_total++;
        close_out();
      end
      check("done flag", {31'h0, st[1]}, 32'h1);
      check("advance flags", {29'h0, st[5:3]}, 32'h0);
      check("lockout", {31'h0, lockout}, {31'h0, op != OP_INDIRECT_JUMP_ENABLE_IRQ});
      rd(REG_PC, q);
      check("program counter", q, {17'h0, exp_pc});
      rd(REG_XREG, q);
      check("x register", q, 32'h0);
      if (jump) begin
        check("pointer word kept", {14'h0, i_mem.mem[up]}, {14'h0, word});
      end else begin
        check("stored pc", {14'h0, i_mem.mem[park]}, {17'h0, pc0});
      end
      $display("test %0d code %h done", k, op);
    end
    close_out();
  end
endmodule : ijs_sequencer_bench
`default_nettype wire
